//--- smbus_cs_cfg.svh
// register addresses, field positions and reset values of the serial bus control/status registers
// assumes an 8-bit special-function register port with a page select
`ifndef SMBUS_CS_CFG_SVH
`define SMBUS_CS_CFG_SVH
`define SB_CS_ADDR      8'hC0
`define SB_PAGE0        4'h0
`define SB_PAGEF        4'hF
`define SB_CS_RESET     8'h00
`define SB_BIT_CTRL     7
`define SB_BIT_TXDIR    6
`define SB_BIT_BEGIN    5
`define SB_BIT_HALT     4
`define SB_BIT_ACKRQ    3
`define SB_BIT_ARBLOST  2
`define SB_BIT_ACK      1
`define SB_BIT_SERVICE  0
`endif

//--- smbus_cs_pkg.sv
// types shared by the control/status block and its per-interface register slice
// assumes nothing of its surroundings
package smbus_cs_pkg;
  typedef logic [7:0] byte_t;
endpackage

//--- smbus_cs_if.sv
// bundle between the register port decode and one interface's register slice
// assumes a single clock domain
interface smbus_cs_if;
  import smbus_cs_pkg::*;
  logic  wr;
  logic  bit_wr;
  logic  [2:0] bit_sel;
  logic  bit_val;
  byte_t wdata;
  byte_t rdata;
  modport top (output wr, bit_wr, bit_sel, bit_val, wdata, input rdata);
  modport slice (input wr, bit_wr, bit_sel, bit_val, wdata, output rdata);
endinterface

//--- smbus_cs_slice.sv
// one interface's control/status register and its hardware set/clear logic
// assumes engine events are single-cycle pulses on core_clk_i
`include "smbus_cs_cfg.svh"
module smbus_cs_slice
  import smbus_cs_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  smbus_cs_if.slice bus,
  input  wire logic master_set_i,
  input  wire logic master_clr_i,
  input  wire logic tx_set_i,
  input  wire logic tx_clr_i,
  input  wire logic start_det_i,
  input  wire logic stop_det_i,
  input  wire logic stop_sent_i,
  input  wire logic byte_rx_i,
  input  wire logic ack_cycle_i,
  input  wire logic ack_rx_valid_i,
  input  wire logic ack_rx_i,
  input  wire logic arb_lost_i,
  input  wire logic event_i,
  input  wire logic hw_ack_en_i,
  output logic      gen_start_o,
  output logic      gen_stop_o,
  output logic      ack_out_o,
  output logic      ack_written_o,
  output logic      hold_scl_o,
  output logic      advance_o
);
  logic controller_indicator, transmit_direction, begin_flag, halt_flag;
  logic acknowledge_request, arbitration_lost, ack_bit, service_flag, ack_wr_seen;
  logic [7:0] wbits, wmask;

  // byte write touches all bits, bit write one bit
  always_comb begin
    wmask = bus.wr ? 8'hFF : (bus.bit_wr ? (8'h01 << bus.bit_sel) : 8'h00);
    wbits = bus.wr ? bus.wdata : (bus.bit_val ? 8'hFF : 8'h00);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) controller_indicator <= 1'b0;
    else if (master_set_i) controller_indicator <= 1'b1;
    else if (master_clr_i | arb_lost_i) controller_indicator <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) transmit_direction <= 1'b0;
    else if (tx_set_i) transmit_direction <= 1'b1;
    else if (tx_clr_i | start_det_i | arb_lost_i) transmit_direction <= 1'b0;
  end

  // hardware detection wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin_flag <= 1'b0;
    else if (start_det_i) begin_flag <= 1'b1;
    else if (wmask[`SB_BIT_BEGIN]) begin_flag <= wbits[`SB_BIT_BEGIN];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) halt_flag <= 1'b0;
    else if (stop_det_i & ~controller_indicator) halt_flag <= 1'b1;
    else if (stop_sent_i) halt_flag <= 1'b0;
    else if (wmask[`SB_BIT_HALT]) halt_flag <= wbits[`SB_BIT_HALT];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) acknowledge_request <= 1'b0;
    else if (byte_rx_i & ~hw_ack_en_i) acknowledge_request <= 1'b1;
    else if (ack_cycle_i) acknowledge_request <= 1'b0;
  end

  logic svc_clear;
  assign svc_clear = wmask[`SB_BIT_SERVICE] & ~wbits[`SB_BIT_SERVICE];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) arbitration_lost <= 1'b0;
    else if (arb_lost_i) arbitration_lost <= 1'b1;
    else if (svc_clear) arbitration_lost <= 1'b0;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) service_flag <= 1'b0;
    else if (event_i | arb_lost_i) service_flag <= 1'b1;
    else if (wmask[`SB_BIT_SERVICE]) service_flag <= wbits[`SB_BIT_SERVICE];
  end

  // with hardware acknowledge off, unwritten acknowledge defaults to nack when the byte is released
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_bit <= 1'b0;
      ack_wr_seen <= 1'b0;
    end else if (wmask[`SB_BIT_ACK]) begin
      ack_bit <= wbits[`SB_BIT_ACK];
      ack_wr_seen <= 1'b1;
    end else if (ack_rx_valid_i) begin
      ack_bit <= ack_rx_i;
    end else if (byte_rx_i) begin
      ack_wr_seen <= 1'b0;
    end
  end

  assign gen_start_o   = begin_flag & ~service_flag;
  assign gen_stop_o    = halt_flag & controller_indicator;
  assign ack_out_o     = ack_bit & (ack_wr_seen | hw_ack_en_i);
  assign ack_written_o = ack_wr_seen;
  assign hold_scl_o    = service_flag;
  // a lost arbitration in the same cycle re-raises the flag, so no advance then
  assign advance_o     = svc_clear & service_flag & ~event_i & ~arb_lost_i;
  assign bus.rdata = {controller_indicator, transmit_direction, begin_flag, halt_flag,
                      acknowledge_request, arbitration_lost, ack_bit, service_flag};
endmodule

//--- smbus_control_status.sv
// control/status registers of two independent serial bus interfaces on the sfr port
// assumes engine event inputs are synchronous one-cycle pulses from core_clk_i logic
// Operation
// - bit 7 reads 1 while acting as bus master, 0 as slave.
// - bit 6 reads 1 while transmitting current byte, 0 while receiving.
// - bit 5 reads 1 once a start or repeated start is detected.
// - writing 1 to bit 5 as master requests a start.
// - bit 4 reads 1 on slave stop detect or pending master stop.
// - writing 1 to bit 4 as master sends stop, hardware then clears it.
// - bit 2 reads 1 after arbitration was lost.
// - hardware sets bit 0; software clears; clock held low while set.
// - first register at 0xC0 page 0, bit-addressable, resets to zero.
// - second register at 0xC0 page F, same layout, bit-addressable.
// - clearing the interrupt flag also clears arbitration lost.
// - software acknowledge mode sets ack request per received byte.
// - receiver sends written ack value or nack; transmitter reads received ack.
`include "smbus_cs_cfg.svh"
module smbus_control_status
  import smbus_cs_pkg::*;
#(
  parameter int N_IF = 2
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  input  wire logic [7:0]      sfr_addr_i,
  input  wire logic [3:0]      sfr_page_i,
  input  wire logic            sfr_wr_i,
  input  wire logic            sfr_bit_wr_i,
  input  wire logic [2:0]      sfr_bit_sel_i,
  input  wire logic            sfr_bit_val_i,
  input  wire logic [7:0]      sfr_wdata_i,
  output logic      [7:0]      sfr_rdata_o,
  output logic                 sfr_hit_o,
  input  wire logic [N_IF-1:0] master_set_i,
  input  wire logic [N_IF-1:0] master_clr_i,
  input  wire logic [N_IF-1:0] tx_set_i,
  input  wire logic [N_IF-1:0] tx_clr_i,
  input  wire logic [N_IF-1:0] start_det_i,
  input  wire logic [N_IF-1:0] stop_det_i,
  input  wire logic [N_IF-1:0] stop_sent_i,
  input  wire logic [N_IF-1:0] byte_rx_i,
  input  wire logic [N_IF-1:0] ack_cycle_i,
  input  wire logic [N_IF-1:0] ack_rx_valid_i,
  input  wire logic [N_IF-1:0] ack_rx_i,
  input  wire logic [N_IF-1:0] arb_lost_i,
  input  wire logic [N_IF-1:0] event_i,
  input  wire logic [N_IF-1:0] hardware_acknowledge_enable_i,
  output logic      [N_IF-1:0] gen_start_o,
  output logic      [N_IF-1:0] gen_stop_o,
  output logic      [N_IF-1:0] ack_out_o,
  output logic      [N_IF-1:0] ack_written_o,
  output logic      [N_IF-1:0] hold_scl_o,
  output logic      [N_IF-1:0] advance_o
);
  // page select decides which interface a 0xC0 access reaches
  function automatic logic page_hit(input logic [7:0] a, input logic [3:0] p, input logic [3:0] want);
    page_hit = (a == `SB_CS_ADDR) && (p == want);
  endfunction

  logic [N_IF-1:0] sel;
  byte_t           rd [N_IF];

  genvar g;
  generate
    for (g = 0; g < N_IF; g++) begin : gen_if
      smbus_cs_if cs ();
      // interface 0 in page 0, interface 1 in page F
      assign sel[g]        = page_hit(sfr_addr_i, sfr_page_i, (g == 0) ? `SB_PAGE0 : `SB_PAGEF);
      assign cs.wr         = sfr_wr_i & sel[g];
      assign cs.bit_wr     = sfr_bit_wr_i & sel[g];
      assign cs.bit_sel    = sfr_bit_sel_i;
      assign cs.bit_val    = sfr_bit_val_i;
      assign cs.wdata      = sfr_wdata_i;
      assign rd[g]         = cs.rdata;
      smbus_cs_slice u_slice (
        .core_clk_i     (core_clk_i),
        .rst_i          (rst_i),
        .bus            (cs.slice),
        .master_set_i   (master_set_i[g]),
        .master_clr_i   (master_clr_i[g]),
        .tx_set_i       (tx_set_i[g]),
        .tx_clr_i       (tx_clr_i[g]),
        .start_det_i    (start_det_i[g]),
        .stop_det_i     (stop_det_i[g]),
        .stop_sent_i    (stop_sent_i[g]),
        .byte_rx_i      (byte_rx_i[g]),
        .ack_cycle_i    (ack_cycle_i[g]),
        .ack_rx_valid_i (ack_rx_valid_i[g]),
        .ack_rx_i       (ack_rx_i[g]),
        .arb_lost_i     (arb_lost_i[g]),
        .event_i        (event_i[g]),
        .hw_ack_en_i    (hardware_acknowledge_enable_i[g]),
        .gen_start_o    (gen_start_o[g]),
        .gen_stop_o     (gen_stop_o[g]),
        .ack_out_o      (ack_out_o[g]),
        .ack_written_o  (ack_written_o[g]),
        .hold_scl_o     (hold_scl_o[g]),
        .advance_o      (advance_o[g])
      );
    end
  endgenerate

  // read mux is combinational; unmapped reads return zero
  always_comb begin
    sfr_rdata_o = `SB_CS_RESET;
    for (int i = 0; i < N_IF; i++) begin
      if (sel[i]) sfr_rdata_o = rd[i];
    end
  end
  assign sfr_hit_o = |sel;
endmodule

//--- smbus_cs_chk.sv
// assertions on the control/status block ports
// assumes binding onto smbus_control_status, one clock domain
module smbus_cs_chk #(
  parameter int N_IF = 2
) (
  input wire logic            core_clk_i,
  input wire logic            rst_i,
  input wire logic [7:0]      sfr_addr_i,
  input wire logic [3:0]      sfr_page_i,
  input wire logic            sfr_wr_i,
  input wire logic [7:0]      sfr_wdata_i,
  input wire logic [7:0]      sfr_rdata_o,
  input wire logic            sfr_hit_o,
  input wire logic [N_IF-1:0] arb_lost_i,
  input wire logic [N_IF-1:0] event_i,
  input wire logic [N_IF-1:0] stop_sent_i,
  input wire logic [N_IF-1:0] gen_start_o,
  input wire logic [N_IF-1:0] gen_stop_o,
  input wire logic [N_IF-1:0] hold_scl_o,
  input wire logic [N_IF-1:0] advance_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  wire wr_if0 = sfr_wr_i && sfr_addr_i == 8'hC0 && sfr_page_i == 4'h0;
  hit_decode_a: assert property (
    sfr_hit_o == (sfr_addr_i == 8'hC0 && (sfr_page_i == 4'h0 || sfr_page_i == 4'hF))) else $error("bad hit");
  unmapped_zero_a: assert property (!sfr_hit_o |-> sfr_rdata_o == 8'h00)
    else $error("unmapped data");
  service_hold_a: assert property (event_i[0] |=> hold_scl_o[0])
    else $error("no clock hold");
  start_request_a: assert property (
    wr_if0 && sfr_wdata_i[5] && !sfr_wdata_i[0] && !event_i[0] && !arb_lost_i[0] |=> gen_start_o[0])
    else $error("no start");
  stop_clear_a: assert property (gen_stop_o[0] && stop_sent_i[0] |=> !gen_stop_o[0])
    else $error("stop kept");
  advance_pulse_a: assert property (
    hold_scl_o[0] && wr_if0 && !sfr_wdata_i[0] && !event_i[0] && !arb_lost_i[0] |-> advance_o[0])
    else $error("no advance");
  arb_hold_a: assert property (arb_lost_i[1] |=> hold_scl_o[1])
    else $error("arb no hold");
  if_isolation_a: assert property (
    wr_if0 && !event_i[1] && !arb_lost_i[1] |=> $stable(hold_scl_o[1])) else $error("if1 disturbed");
endmodule
bind smbus_control_status smbus_cs_chk #(.N_IF(N_IF)) chk_u (
  .core_clk_i  (core_clk_i),
  .rst_i       (rst_i),
  .sfr_addr_i  (sfr_addr_i),
  .sfr_page_i  (sfr_page_i),
  .sfr_wr_i    (sfr_wr_i),
  .sfr_wdata_i (sfr_wdata_i),
  .sfr_rdata_o (sfr_rdata_o),
  .sfr_hit_o   (sfr_hit_o),
  .arb_lost_i  (arb_lost_i),
  .event_i     (event_i),
  .stop_sent_i (stop_sent_i),
  .gen_start_o (gen_start_o),
  .gen_stop_o  (gen_stop_o),
  .hold_scl_o  (hold_scl_o),
  .advance_o   (advance_o)
);

//--- far_side_model.sv
// far-side engine stand-in: answers start and stop requests once each
// assumes request outputs of the block are levels on core_clk_i
module far_side_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] gen_start_i,
  input  wire logic [1:0] gen_stop_i,
  input  wire logic [1:0] hold_i,
  output logic      [1:0] start_det_o,
  output logic      [1:0] event_o,
  output logic      [1:0] stop_sent_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // silent while the clock line is held low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_det_o <= '0;
      stop_sent_o <= '0;
    end else begin
      start_det_o <= gen_start_i & ~hold_i & ~start_det_o;
      stop_sent_o <= gen_stop_i & ~hold_i & ~stop_sent_o;
    end
  end
  assign event_o = start_det_o;
endmodule

//--- smbus_control_status_tb.sv
// self-checking bench for the two control/status registers
// assumes far_side_model answers start and stop requests
module smbus_control_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i = '0, rst_i = '1, sfr_wr_i = '0, sfr_bit_wr_i = '0, sfr_bit_val_i = '0, sfr_hit_o;
  logic [7:0] sfr_addr_i = 8'hC0, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [3:0] sfr_page_i = 4'h0, obs;
  logic [2:0] sfr_bit_sel_i = 3'h0;
  logic [1:0] master_clr_i = '0, tx_clr_i = '0, ack_rx_i = '0, hardware_acknowledge_enable_i = '0;
  logic [1:0] master_set_i, tx_set_i, stop_det_i, byte_rx_i, ack_cycle_i, ack_rx_valid_i, arb_lost_i;
  logic [1:0] start_det_i, event_i, stop_sent_i, gen_start_o, gen_stop_o, ack_out_o, ack_written_o;
  logic [1:0] hold_scl_o, advance_o;
  logic [13:0] pul = '0;
  int         fail_count = 0;
  int         n_compared = 0;
  logic [7:0] adv0 = 8'h00, adv1 = 8'h00;
  assign {ack_rx_valid_i, ack_cycle_i, byte_rx_i, stop_det_i, arb_lost_i, tx_set_i, master_set_i} = pul;
  assign obs = {gen_stop_o, hold_scl_o};
  smbus_control_status dut_u (.*);
  far_side_model far_u (.core_clk_i, .rst_i, .gen_start_i(gen_start_o), .gen_stop_i(gen_stop_o),
    .hold_i(hold_scl_o), .start_det_o(start_det_i), .event_o(event_i), .stop_sent_o(stop_sent_i));
  always #50 core_clk_i = ~core_clk_i;
  // advance stands for one cycle only, so count it where it stands
  always @(negedge core_clk_i) begin
    if (advance_o[0]) adv0 <= adv0 + 8'h01;
    if (advance_o[1]) adv1 <= adv1 + 8'h01;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("compared=%0d failed=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // b selects a bit write: d[2:0] picks the bit, d[3] is its value
  task automatic wr(input logic [3:0] p, input logic [7:0] d, input logic b);
    @(posedge core_clk_i);
    sfr_page_i <= p;
    sfr_wdata_i <= d;
    sfr_bit_sel_i <= d[2:0];
    sfr_bit_val_i <= d[3];
    sfr_wr_i <= !b;
    sfr_bit_wr_i <= b;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
    sfr_bit_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] e);
    @(posedge core_clk_i);
    sfr_page_i <= p;
    @(negedge core_clk_i);
    chk(sfr_rdata_o, e);
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge core_clk_i);
    pul <= m;
    @(posedge core_clk_i);
    pul <= '0;
  endtask
  // partner latency is ours, so wait on the outcome instead of a count
  task automatic wt(input int s, input logic v);
    int k;
    // look only at falling edges: a flag launched on this rising edge is not settled yet
    for (k = 0; k < 50; k++) begin
      @(negedge core_clk_i);
      if (obs[s] === v) break;
    end
    if (k == 50) begin
      fail_count++;
      test_done;
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'hF, 8'h00);
    rd(4'h1, 8'h00);
    chk({7'h00, sfr_hit_o}, 8'h00);
    @(posedge core_clk_i);
    sfr_addr_i <= 8'hC1;
    wr(4'h0, 8'hFF, 1'b0);
    rd(4'h0, 8'h00);
    chk({7'h00, sfr_hit_o}, 8'h00);
    @(posedge core_clk_i);
    sfr_addr_i <= 8'hC0;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hFF, 1'b0);
    rd(4'h0, 8'h33);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'h00, 1'b0);
    pulse(14'h1);
    wr(4'h0, 8'h20, 1'b0);
    wt(0, 1'b1);
    rd(4'h0, 8'hA1);
    wr(4'h0, 8'h10, 1'b0);
    wt(2, 1'b0);
    rd(4'h0, 8'h80);
    pulse(14'hA);
    rd(4'hF, 8'hC0);
    pulse(14'h20);
    rd(4'hF, 8'h05);
    wr(4'hF, 8'h00, 1'b1);
    rd(4'hF, 8'h00);
    pulse(14'h80);
    rd(4'hF, 8'h10);
    pulse(14'h100);
    rd(4'h0, 8'h88);
    chk({7'h00, ack_out_o[0]}, 8'h00);
    wr(4'h0, 8'h09, 1'b1);
    rd(4'h0, 8'h8A);
    chk({7'h00, ack_out_o[0]}, 8'h01);
    chk({7'h00, ack_written_o[0]}, 8'h01);
    pulse(14'h100);
    rd(4'h0, 8'h8A);
    chk({7'h00, ack_out_o[0]}, 8'h00);
    chk({7'h00, ack_written_o[0]}, 8'h00);
    pulse(14'h400);
    rd(4'h0, 8'h82);
    pulse(14'h1000);
    rd(4'h0, 8'h80);
    chk(adv0, 8'h02);
    chk(adv1, 8'h01);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'hF, 8'h00);
    test_done;
  end
endmodule
